/* dru_upgrade.sv */
/*
  Dual-image remote upgrade controller: image selection, revert on error,
  watchdog, serial upgrade shift/input registers and an AHB-Lite register slave.
  Assumes pins and core upgrade signals are asynchronous to hclk; the upgrade
  clock is oversampled, so it must stay well below hclk/4.
*/
`default_nettype none

// Notes on behaviour
// RL1: Upgrade enabled by default in dual-image mode.
// RL2: Two images held; exactly one loaded each time.
// RL3: Image pin sampled at power-up; register may override.
// RL4: CRC error or watchdog timeout reverts other image.
// RL5: After revert, failure cause and image are readable.
// RL6: Second error waits, unless auto-restart reconfigures now.
// RL7: Status low, config low or core request reconfigure.
// RL8: Core request acts only with upgrade enabled.
// RL9: Upgrade registers run only in user mode, enabled.
// RL10: Serial input enters shift register while shifting.
// RL11: Serial output advances one bit per shift edge.
// RL12: Update mode copies shift into input register.
// RL13: Capture mode loads shift register from state.
// RL14: Shifting ignores capture-not-update control.
// RL15: Falling edge of kick restarts watchdog.
// RL16: Core holds each kick pulse at least 250 ns.
// RL17: Bits 40 and 39 choose captured source.
// RL18: Image choice bit valid only with override enabled.
// RL19: Lower 39 bits shift toward bit zero.
module dru_upgrade #(
  parameter int LOAD_CYC = 16
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Configuration pins
  input wire logic image_select,
  input wire logic config_status_n,
  input wire logic ext_config_n,
  input wire logic crc_error,
  input wire logic dual_image_mode,
  // Core upgrade port
  input wire logic upgrade_clock,
  input wire logic shift_not_load,
  input wire logic capture_not_update,
  input wire logic upgrade_serial_in,
  input wire logic core_reconfig_request_n,
  input wire logic watchdog_kick_n,
  output logic upgrade_serial_out,
  // Configuration state
  output logic user_mode,
  output logic active_image,
  output logic [3:0] msm_state
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  dru_pkg::dru_pins_t pins_raw;
  dru_pkg::dru_pins_t s1_q;
  dru_pkg::dru_pins_t s2_q;
  dru_pkg::dru_pins_t s3_q;

  assign pins_raw = '{image_select, config_status_n, ext_config_n, crc_error, dual_image_mode,
                      upgrade_clock, shift_not_load, capture_not_update, upgrade_serial_in,
                      core_reconfig_request_n, watchdog_kick_n};

  // Idle levels of active-low inputs reset high so no false event follows reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
      s2_q <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
      s3_q <= '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    end else begin
      s1_q <= pins_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  logic ru_rise;
  logic kick_fall;
  assign ru_rise = s2_q.upgrade_clock & ~s3_q.upgrade_clock;
  // Two-stage sampling at 10 ns sees any kick held for the minimum width
  assign kick_fall = ~s2_q.watchdog_kick_n & s3_q.watchdog_kick_n; // [RL15] [RL16]

  // ----------------------------------------------------------------
  // Control registers and common terms
  // ----------------------------------------------------------------
  logic [2:0] ctrl_q;
  logic [dru_pkg::WD_W-1:0] wdto_q;
  logic [dru_pkg::IN_W-1:0] in_q;
  logic [dru_pkg::SR_W-1:0] sr_q;
  logic [dru_pkg::WD_W-1:0] wd_cnt_q;
  logic [dru_pkg::PREV_W-1:0] prev_q [2];
  dru_pkg::dru_cfg_state_t state_q;
  logic image_q;
  logic reverted_q;
  logic [1:0] cnt_q;
  logic [$clog2(LOAD_CYC+1)-1:0] load_cnt_q;

  function automatic logic [3:0] msm_code(input logic img, input logic rev);
    if (img) begin
      msm_code = rev ? dru_pkg::MSM_IMG1_REV : dru_pkg::MSM_IMG1;
    end else begin
      msm_code = rev ? dru_pkg::MSM_IMG0_REV : dru_pkg::MSM_IMG0;
    end
  endfunction : msm_code

  logic ru_en;
  logic ru_active;
  logic wd_en;
  logic wd_to;
  logic src_cfg;
  logic src_stat;
  logic src_core;
  logic ext_src;
  logic err;
  logic sel_image;
  logic [3:0] src_code;

  assign ru_en = s2_q.dual_image_mode & ctrl_q[dru_pkg::CTRL_RUEN]; // [RL1]
  assign ru_active = (state_q == dru_pkg::ST_USER) & ru_en; // [RL9]
  assign wd_en = ctrl_q[dru_pkg::CTRL_WDEN] & ru_en;
  assign wd_to = wd_en & (wd_cnt_q >= wdto_q);
  assign src_cfg = ~s2_q.ext_config_n; // [RL7]
  assign src_stat = ~s2_q.config_status_n; // [RL7]
  assign src_core = ~s2_q.core_reconfig_request_n & ru_en; // [RL7] [RL8]
  assign ext_src = src_cfg | src_stat | src_core;
  assign err = s2_q.crc_error | wd_to;
  // Override replaces the pin only when its enable bit is set
  assign sel_image = in_q[dru_pkg::IMG_OVR_BIT] ? in_q[dru_pkg::IMG_CHOICE_BIT] : s2_q.image_select; // [RL3] [RL18]

  // Ties go to the higher status bit
  always_comb begin
    if (src_cfg) begin
      src_code = dru_pkg::SRC_CFG;
    end else if (s2_q.crc_error) begin
      src_code = dru_pkg::SRC_CRC;
    end else if (src_stat) begin
      src_code = dru_pkg::SRC_STAT;
    end else if (wd_to) begin
      src_code = dru_pkg::SRC_WD;
    end else begin
      src_code = dru_pkg::SRC_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Configuration sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= dru_pkg::ST_POR;
      image_q <= 1'b0;
      reverted_q <= 1'b0;
      cnt_q <= 2'h0;
      load_cnt_q <= '0;
    end else begin
      case (state_q)
        dru_pkg::ST_POR: begin
          cnt_q <= cnt_q + 2'h1;
          if (cnt_q == 2'(dru_pkg::POR_SETTLE_CYC)) begin
            image_q <= s2_q.image_select; // [RL3]
            state_q <= dru_pkg::ST_LOAD;
            load_cnt_q <= '0;
          end
        end
        dru_pkg::ST_LOAD: begin
          load_cnt_q <= load_cnt_q + 1'b1;
          if (load_cnt_q == ($clog2(LOAD_CYC+1))'(LOAD_CYC - 1)) begin
            state_q <= dru_pkg::ST_USER;
          end
        end
        dru_pkg::ST_USER: begin
          load_cnt_q <= '0;
          if (ext_src) begin
            image_q <= sel_image; // [RL2] [RL7]
            reverted_q <= 1'b0;
            state_q <= dru_pkg::ST_LOAD;
          end else if (err && !reverted_q) begin
            image_q <= ~image_q; // [RL4]
            reverted_q <= 1'b1;
            state_q <= dru_pkg::ST_LOAD;
          end else if (err && ctrl_q[dru_pkg::CTRL_AUTO]) begin
            image_q <= sel_image; // [RL6]
            reverted_q <= 1'b0;
            state_q <= dru_pkg::ST_LOAD;
          end else if (err) begin
            state_q <= dru_pkg::ST_WAIT; // [RL6]
          end
        end
        dru_pkg::ST_WAIT: begin
          load_cnt_q <= '0;
          if (ext_src) begin
            image_q <= sel_image; // [RL7]
            reverted_q <= 1'b0;
            state_q <= dru_pkg::ST_LOAD;
          end
        end
        default: begin
          state_q <= dru_pkg::ST_POR;
        end
      endcase
    end
  end

  // Record why the running image was left, indexed by that image
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_q[0] <= '0;
      prev_q[1] <= '0;
    end else if (state_q == dru_pkg::ST_USER && (ext_src || err)) begin
      prev_q[image_q] <= {src_code, 2'h0, msm_code(image_q, reverted_q), 22'h000000}; // [RL5]
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wd_cnt_q <= '0;
    end else if (state_q != dru_pkg::ST_USER || !wd_en || kick_fall) begin
      wd_cnt_q <= '0; // [RL15]
    end else if (!wd_to) begin
      wd_cnt_q <= wd_cnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Upgrade shift and input registers
  // ----------------------------------------------------------------
  logic [dru_pkg::IN_W-1:0] cur_state;
  assign cur_state = {5'h00, msm_code(image_q, reverted_q), wd_en, wdto_q};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sr_q <= '0;
    end else if (ru_active && ru_rise) begin // [RL9]
      if (s2_q.shift_not_load) begin // [RL14]
        // Select bits ride above the data field so they can be written too
        sr_q[dru_pkg::SEL_HI] <= s2_q.upgrade_serial_in;
        sr_q[dru_pkg::SEL_LO] <= sr_q[dru_pkg::SEL_HI];
        sr_q[dru_pkg::IN_W-1:0] <= {s2_q.upgrade_serial_in, sr_q[dru_pkg::IN_W-1:1]}; // [RL10] [RL11] [RL19]
      end else if (s2_q.capture_not_update) begin
        case (sr_q[dru_pkg::SEL_HI:dru_pkg::SEL_LO]) // [RL13] [RL17]
          dru_pkg::CAP_CURRENT: sr_q[dru_pkg::IN_W-1:0] <= cur_state;
          dru_pkg::CAP_PREV_APP1: sr_q[dru_pkg::IN_W-1:0] <= {7'h00, prev_q[0]};
          dru_pkg::CAP_PREV_APP2: sr_q[dru_pkg::IN_W-1:0] <= {7'h00, prev_q[1]};
          default: sr_q[dru_pkg::IN_W-1:0] <= in_q;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_q <= '0;
    end else if (ru_active && ru_rise && !s2_q.shift_not_load && !s2_q.capture_not_update) begin
      in_q <= sr_q[dru_pkg::IN_W-1:0]; // [RL12]
    end
  end

  assign upgrade_serial_out = sr_q[0]; // [RL11]
  assign user_mode = (state_q == dru_pkg::ST_USER);
  assign active_image = image_q;
  assign msm_state = msm_code(image_q, reverted_q);

  // ----------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------
  logic wr_q;
  logic [7:0] waddr_q;
  logic [31:0] rdata_q;
  logic take;
  assign take = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      waddr_q <= 8'h00;
      rdata_q <= 32'h00000000;
    end else begin
      wr_q <= take & hwrite;
      waddr_q <= haddr[7:0];
      if (take && !hwrite) begin
        case (haddr[7:0])
          dru_pkg::OFS_CTRL: rdata_q <= {29'h00000000, ctrl_q};
          dru_pkg::OFS_WDTO: rdata_q <= {3'h0, wdto_q};
          dru_pkg::OFS_STAT: rdata_q <= {19'h00000, state_q, ru_en, user_mode, reverted_q, image_q,
                                         msm_code(image_q, reverted_q), 1'b0, wd_en, 1'b0};
          dru_pkg::OFS_INREG: rdata_q <= {18'h00000, in_q[dru_pkg::IMG_CHOICE_BIT:0]};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= dru_pkg::CTRL_RST;
      wdto_q <= dru_pkg::WDTO_RST;
    end else if (wr_q) begin
      if (waddr_q == dru_pkg::OFS_CTRL) begin
        ctrl_q <= hwdata[2:0];
      end
      if (waddr_q == dru_pkg::OFS_WDTO) begin
        wdto_q <= hwdata[dru_pkg::WD_W-1:0];
      end
    end
  end

  assign hrdata = rdata_q;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_serial_in_enter: assert property (ru_active && ru_rise && s2_q.shift_not_load
    |=> sr_q[38] == $past(s2_q.upgrade_serial_in)) else $error("serial input not taken"); // [RL10]
  a_shift_advance: assert property (ru_active && ru_rise && s2_q.shift_not_load
    |=> upgrade_serial_out == $past(sr_q[1]) && sr_q[37:0] == $past(sr_q[38:1]))
    else $error("shift register did not advance"); // [RL11] [RL19]
  a_update_copy: assert property (ru_active && ru_rise && !s2_q.shift_not_load && !s2_q.capture_not_update
    |=> in_q == $past(sr_q[38:0])) else $error("update did not copy"); // [RL12]
  a_capture_input: assert property (ru_active && ru_rise && !s2_q.shift_not_load && s2_q.capture_not_update
    && sr_q[40:39] == 2'h3 |=> sr_q[38:0] == $past(in_q)) else $error("capture of input wrong"); // [RL13] [RL17]
  a_idle_hold: assert property (!ru_active |=> $stable(sr_q) && $stable(in_q))
    else $error("upgrade registers moved while disabled"); // [RL9]
  a_kick_clears: assert property (kick_fall |=> wd_cnt_q == '0)
    else $error("watchdog not restarted by kick"); // [RL15]
  a_revert_other: assert property (state_q == dru_pkg::ST_USER && err && !reverted_q && !ext_src
    |=> state_q == dru_pkg::ST_LOAD && image_q != $past(image_q) && reverted_q)
    else $error("no revert to other image"); // [RL4]
  a_second_wait: assert property (state_q == dru_pkg::ST_USER && err && reverted_q && !ext_src
    && !ctrl_q[dru_pkg::CTRL_AUTO] |=> (state_q == dru_pkg::ST_WAIT)
    ##1 (state_q == dru_pkg::ST_WAIT || $past(ext_src)))
    else $error("second error did not wait"); // [RL6]
  a_core_gated: assert property (state_q == dru_pkg::ST_USER && !ru_en && !src_cfg && !src_stat && !err
    |=> state_q == dru_pkg::ST_USER) else $error("core request acted while disabled"); // [RL8]
  a_por_sample: assert property (state_q == dru_pkg::ST_POR && cnt_q == 2'h2
    |=> image_q == $past(s2_q.image_select)) else $error("power-up image pin not sampled"); // [RL3]
  a_prev_record: assert property (state_q == dru_pkg::ST_USER && err && !ext_src
    |=> prev_q[$past(image_q)][31:28] == $past(src_code) && $past(src_code) != 4'h0)
    else $error("failure cause not recorded"); // [RL5]

endmodule : dru_upgrade

`default_nettype wire

/* dru_pkg.sv */
/*
  Constants, field layouts and types shared by the dual-image remote upgrade block.
  Assumes a single 100 MHz bus clock and a 32-bit AHB-Lite register bus.
*/
`default_nettype none

package dru_pkg;

  // ----------------------------------------------------------------
  // Upgrade shift and input registers
  // ----------------------------------------------------------------
  localparam int SR_W = 41;
  localparam int IN_W = 39;
  localparam int SEL_HI = 40;
  localparam int SEL_LO = 39;
  localparam int IMG_CHOICE_BIT = 13;
  localparam int IMG_OVR_BIT = 12;
  localparam logic [1:0] CAP_CURRENT = 2'h0;
  localparam logic [1:0] CAP_PREV_APP1 = 2'h1;
  localparam logic [1:0] CAP_PREV_APP2 = 2'h2;
  localparam logic [1:0] CAP_INPUT = 2'h3;

  // ----------------------------------------------------------------
  // Status layouts and state codes
  // ----------------------------------------------------------------
  localparam int WD_W = 29;
  localparam int PREV_W = 32;
  localparam int PREV_SRC_LO = 28;
  localparam int PREV_MSM_LO = 22;
  localparam logic [3:0] SRC_CFG = 4'h8;
  localparam logic [3:0] SRC_CRC = 4'h4;
  localparam logic [3:0] SRC_STAT = 4'h2;
  localparam logic [3:0] SRC_WD = 4'h1;
  localparam logic [3:0] SRC_NONE = 4'h0;
  localparam logic [3:0] MSM_IMG0 = 4'h2;
  localparam logic [3:0] MSM_IMG1_REV = 4'h3;
  localparam logic [3:0] MSM_IMG1 = 4'h4;
  localparam logic [3:0] MSM_IMG0_REV = 4'h5;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WDTO = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_INREG = 8'h0C;
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_WDEN = 1;
  localparam int CTRL_RUEN = 2;
  localparam logic [2:0] CTRL_RST = 3'h6;
  localparam logic [28:0] WDTO_RST = 29'h00001FFF;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int KICK_MIN_NS = 250;
  localparam int KICK_MIN_CYC = (KICK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POR_SETTLE_CYC = 2;

  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_LOAD = 2'b01,
    ST_USER = 2'b10,
    ST_WAIT = 2'b11
  } dru_cfg_state_t;

  typedef struct packed {
    logic image_select;
    logic config_status_n;
    logic ext_config_n;
    logic crc_error;
    logic dual_image_mode;
    logic upgrade_clock;
    logic shift_not_load;
    logic capture_not_update;
    logic upgrade_serial_in;
    logic core_reconfig_request_n;
    logic watchdog_kick_n;
  } dru_pins_t;

endpackage : dru_pkg

`default_nettype wire

/* dru_core_model.sv */
/*
  Model of the core user logic that drives the upgrade port of dru_upgrade.
  Assumes hclk is the 100 MHz bus clock; the upgrade clock is made from it.
*/
`default_nettype none

module dru_core_model (
  // Clock
  input wire logic hclk,
  // Upgrade port
  input wire logic upgrade_serial_out,
  output logic upgrade_clock,
  output logic shift_not_load,
  output logic capture_not_update,
  output logic upgrade_serial_in,
  output logic core_reconfig_request_n,
  output logic watchdog_kick_n
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    upgrade_clock = 1'b0;
    shift_not_load = 1'b0;
    capture_not_update = 1'b0;
    upgrade_serial_in = 1'b0;
    core_reconfig_request_n = 1'b1;
    watchdog_kick_n = 1'b1;
  end

  // ----------------------------------------------------------------
  // Upgrade clock edges
  // ----------------------------------------------------------------
  // Phases of four hclk keep clear of the oversampling limit; clock idles low
  task automatic ru_edge(input logic sl, input logic cu, input logic din);
    @(posedge hclk);
    shift_not_load <= sl;
    capture_not_update <= cu;
    upgrade_serial_in <= din;
    repeat (4) @(posedge hclk);
    upgrade_clock <= 1'b1;
    repeat (4) @(posedge hclk);
    upgrade_clock <= 1'b0;
  endtask : ru_edge

  // Capture-not-update toggles while shifting: it must have no effect
  task automatic shift_word(input logic [40:0] v, input int n, output logic [40:0] got);
    got = '0;
    for (int i = 0; i < n; i++) begin
      got[i] = upgrade_serial_out;
      ru_edge(1'b1, i[0], v[i]);
    end
    upgrade_serial_in <= ~v[n-1];
  endtask : shift_word

  // ----------------------------------------------------------------
  // Watchdog kick and reconfigure request
  // ----------------------------------------------------------------
  task automatic kick();
    @(posedge hclk);
    watchdog_kick_n <= 1'b0;
    repeat (dru_pkg::KICK_MIN_CYC) @(posedge hclk);
    watchdog_kick_n <= 1'b1;
    repeat (dru_pkg::KICK_MIN_CYC) @(posedge hclk);
  endtask : kick

  task automatic reconf();
    @(posedge hclk);
    core_reconfig_request_n <= 1'b0;
    repeat (4) @(posedge hclk);
    core_reconfig_request_n <= 1'b1;
  endtask : reconf

endmodule : dru_core_model

`default_nettype wire

/* tb_top.sv */
/*
  Self-checking testbench for dru_upgrade: AHB-Lite register tasks and
  upgrade port sequences through the core model.
  Assumes the design answers with zero wait states and LOAD_CYC of 16.
*/
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic image_select, config_status_n, ext_config_n, crc_error, dual_image_mode;
  logic upgrade_clock, shift_not_load, capture_not_update, upgrade_serial_in;
  logic core_reconfig_request_n, watchdog_kick_n, upgrade_serial_out;
  logic user_mode, active_image;
  logic [3:0] msm_state;
  logic [40:0] got;
  int failures, num_checks;

  dru_upgrade #(.LOAD_CYC(16)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .image_select(image_select),
    .config_status_n(config_status_n), .ext_config_n(ext_config_n), .crc_error(crc_error),
    .dual_image_mode(dual_image_mode), .upgrade_clock(upgrade_clock), .shift_not_load(shift_not_load),
    .capture_not_update(capture_not_update), .upgrade_serial_in(upgrade_serial_in),
    .core_reconfig_request_n(core_reconfig_request_n), .watchdog_kick_n(watchdog_kick_n),
    .upgrade_serial_out(upgrade_serial_out), .user_mode(user_mode), .active_image(active_image),
    .msm_state(msm_state));

  dru_core_model u_core (.hclk(hclk), .upgrade_serial_out(upgrade_serial_out),
    .upgrade_clock(upgrade_clock), .shift_not_load(shift_not_load),
    .capture_not_update(capture_not_update), .upgrade_serial_in(upgrade_serial_in),
    .core_reconfig_request_n(core_reconfig_request_n), .watchdog_kick_n(watchdog_kick_n));

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [40:0] seen, input logic [40:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic wait_mode(input logic lvl);
    int n;
    n = 0;
    while (user_mode !== lvl && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 3000) begin
      failures++;
      $display("MISMATCH user_mode wait expected %b seen %b", lvl, user_mode);
      stop_test();
    end
  endtask : wait_mode

  // ----------------------------------------------------------------
  // AHB-Lite master
  // ----------------------------------------------------------------
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1 && n < 20) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 20) begin
      failures++;
      $display("MISMATCH hready wait expected 1 seen %b", hreadyout);
      stop_test();
    end
  endtask : wait_ready

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    q = hrdata;
  endtask : ahb

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000, rd);
    check(what, {9'h000, rd}, {9'h000, exp});
  endtask : rd_chk

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    failures = 0;
    num_checks = 0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h00000000;
    image_select = 1'b0;
    config_status_n = 1'b1;
    ext_config_n = 1'b1;
    crc_error = 1'b0;
    dual_image_mode = 1'b1;
    repeat (2) @(posedge hclk);
    check("reset outputs", {hrdata, hreadyout, hresp, upgrade_serial_out, user_mode, msm_state},
      {32'h00000000, 1'b1, 1'b0, 1'b0, 1'b0, dru_pkg::MSM_IMG0});
    hresetn <= 1'b1;
    rd_chk("ctrl reset", dru_pkg::OFS_CTRL, {29'h0, dru_pkg::CTRL_RST});
    rd_chk("wdto reset", dru_pkg::OFS_WDTO, {3'h0, dru_pkg::WDTO_RST});
    ahb(1'b1, 8'h40, 32'hFFFFFFFF, rd);
    rd_chk("unmapped", 8'h40, 32'h00000000);
    wait_mode(1'b1);
    check("boot image", {active_image, msm_state}, {1'b0, dru_pkg::MSM_IMG0});
    $display("TEST boot done");

    // Shift in an override for image 1, update, read back via capture
    u_core.shift_word(41'h0060_0000_3000, 39, got);
    u_core.ru_edge(1'b0, 1'b0, 1'b0);
    rd_chk("input register", dru_pkg::OFS_INREG, 32'h00003000);
    u_core.ru_edge(1'b0, 1'b1, 1'b0);
    u_core.shift_word('0, 39, got);
    check("capture input", got[38:0], 39'h60_0000_3000);
    u_core.ru_edge(1'b0, 1'b1, 1'b0);
    u_core.shift_word('0, 39, got);
    check("capture current", got[38:0], {5'h00, dru_pkg::MSM_IMG0, 1'b1, dru_pkg::WDTO_RST});
    $display("TEST upgrade shift done");

    // Core request ignored while upgrade is disabled
    ahb(1'b1, dru_pkg::OFS_CTRL, 32'h00000002, rd);
    u_core.reconf();
    repeat (40) @(posedge hclk);
    check("request disabled", user_mode, 1'b1);
    ahb(1'b1, dru_pkg::OFS_CTRL, 32'h00000006, rd);
    u_core.reconf();
    wait_mode(1'b0);
    wait_mode(1'b1);
    check("override image", {active_image, msm_state}, {1'b1, dru_pkg::MSM_IMG1});
    $display("TEST core reconfigure done");

    // Kicks hold the watchdog off; silence lets it expire and revert
    ahb(1'b1, dru_pkg::OFS_WDTO, 32'd100, rd);
    for (int i = 0; i < 8; i++) begin
      u_core.kick();
    end
    check("kicked", {user_mode, active_image}, 2'b11);
    wait_mode(1'b0);
    wait_mode(1'b1);
    ahb(1'b1, dru_pkg::OFS_CTRL, 32'h00000004, rd);
    check("revert image", {active_image, msm_state}, {1'b0, dru_pkg::MSM_IMG0_REV});
    for (int k = 1; k <= 2; k++) begin
      u_core.shift_word({39'h0, k[1], k[0]}, 2, got);
      u_core.ru_edge(1'b0, 1'b1, 1'b0);
      u_core.shift_word('0, 39, got);
      check("capture previous", got[38:0], (k == 1) ? 39'h00_0080_0000 : 39'h00_1100_0000);
    end
    $display("TEST watchdog revert done");

    // Second error waits for a reconfiguration source
    crc_error <= 1'b1;
    wait_mode(1'b0);
    crc_error <= 1'b0;
    repeat (100) @(posedge hclk);
    check("second error", user_mode, 1'b0);
    ahb(1'b0, dru_pkg::OFS_STAT, 32'h00000000, rd);
    check("wait state", rd[12:11], 2'h3);
    ext_config_n <= 1'b0;
    repeat (4) @(posedge hclk);
    ext_config_n <= 1'b1;
    wait_mode(1'b1);
    check("external restart", user_mode, 1'b1);
    $display("TEST second error done");

    // Auto-restart: first error reverts, the next one reloads the selected image at once
    ahb(1'b1, dru_pkg::OFS_CTRL, 32'h00000005, rd);
    crc_error <= 1'b1;
    wait_mode(1'b0);
    crc_error <= 1'b0;
    wait_mode(1'b1);
    check("first error", {active_image, msm_state}, {1'b0, dru_pkg::MSM_IMG0_REV});
    crc_error <= 1'b1;
    wait_mode(1'b0);
    crc_error <= 1'b0;
    wait_mode(1'b1);
    check("auto restart", {active_image, msm_state}, {1'b1, dru_pkg::MSM_IMG1});
    $display("TEST auto restart done");
    stop_test();
  end

endmodule : tb_top

`default_nettype wire
